// ### quad_dac_loader_pkg.sv
/*
  constants shared by the quad converter serial loader: command word layout,
  register map of the control bus, reset values and bus response codes.
  assumes a single top module that reads everything through the package scope.
*/
// Behaviour
// - a command word is 11 bits: 8 code bits, 2 channel select bits and one range bit.
// - the range bit picks unity or doubled span for the addressed channel and is stored with its code.
// - four independent channels each hold their own 8-bit output code.
// - serial data is shifted in on every falling serial clock edge and on no other edge.
// - with the update strobe low, a falling latch strobe moves the word straight to the channel output.
// - with the update strobe high, commands only reach the holding latches, and the outputs only through a soft update.
// - a falling update strobe copies every holding latch into its output latch.
// - each channel has a holding latch and a separate output latch for a joint update.
// - an internal power-on reset forces all channel latches to a fixed state; here the external aresetn input clears them to zero instead.
// - after power-up every output code is zero.
// - command bits travel most significant bit first.
package quad_dac_loader_pkg;
  // ==========================================================
  // command word layout
  localparam int WORD_BITS = 11;
  localparam int CODE_BITS = 8;
  localparam int CHANNELS = 4;
  localparam int SEL_HI_POS = 10;
  localparam int SEL_LO_POS = 9;
  localparam int RANGE_POS = 8;
  localparam int CODE_MSB = 7;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic RANGE_RESET = 1'b0;
  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] STATUS_OFFS = 8'h04;
  localparam logic [7:0] LAST_CMD_OFFS = 8'h08;
  localparam logic [7:0] OUT_BASE_OFFS = 8'h10;
  localparam logic [7:0] HOLD_BASE_OFFS = 8'h20;
  localparam int ADDR_BITS = 8;
  // control fields
  localparam int CTRL_LINK_EN_POS = 0;
  localparam int CTRL_SOFT_UPD_POS = 1;
  localparam logic CTRL_LINK_EN_RESET = 1'b1;
  // status fields
  localparam int STATUS_UPD_POS = 0;
  localparam int STATUS_LOAD_POS = 1;
  localparam int STATUS_COUNT_LSB = 8;
  // per-channel register fields
  localparam int CHAN_RANGE_POS = 8;
  // ==========================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : quad_dac_loader_pkg

// ### quad_dac_serial_loader.sv
/*
  digital front end of a four channel 8-bit converter: serial shift register on
  the link clock, double-buffered channel latches and a register bus slave.
  assumes the serial clock is idle while the latch strobe is low, so the
  shifted word is stable when the bus clock domain picks it up.
*/
`timescale 1ns/1ps
module quad_dac_serial_loader (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic latch_strobe_n,
  input wire logic output_update_strobe,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [7:0] output_channel_a,
  output logic [7:0] output_channel_b,
  output logic [7:0] output_channel_c,
  output logic [7:0] output_channel_d,
  output logic range_double_a,
  output logic range_double_b,
  output logic range_double_c,
  output logic range_double_d
);
  // ==========================================================
  // link domain: reset synchroniser and shift register
  logic [1:0] link_rst_sync_ff;
  logic link_rst_n;
  logic [10:0] shift_ff;
  logic [10:0] nxt_shift;

  // reset level brought onto the serial clock; first stage feeds only the second
  always_ff @(negedge serial_clock) begin
    link_rst_sync_ff <= {link_rst_sync_ff[0], aresetn};
  end
  assign link_rst_n = link_rst_sync_ff[1];

  // msb arrives first, so shifting left leaves it at the top once 11 bits are in
  always_comb begin
    nxt_shift = {shift_ff[9:0], serial_data};
  end

  // falling edge only; the rising edge never touches the word
  always_ff @(negedge serial_clock) begin
    if (!link_rst_n) begin
      shift_ff <= '0;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  // ==========================================================
  // strobe synchronisers and edge detectors in the bus domain
  logic [2:0] load_sync_ff;
  logic [2:0] upd_sync_ff;
  logic load_fall;
  logic upd_fall;
  logic upd_level;

  // two stages against metastability, third one remembers the last level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_sync_ff <= 3'h7; // latch strobe idles high
      upd_sync_ff <= 3'h0; // low start: a strobe idling either way never shows a false fall after reset
    end else begin
      load_sync_ff <= {load_sync_ff[1:0], latch_strobe_n};
      upd_sync_ff <= {upd_sync_ff[1:0], output_update_strobe};
    end
  end
  // one pulse per synchronised edge; a pin that bounces across several clock cycles fires once per fall
  assign load_fall = load_sync_ff[2] & ~load_sync_ff[1];
  assign upd_fall = upd_sync_ff[2] & ~upd_sync_ff[1];
  assign upd_level = upd_sync_ff[1];

  // ==========================================================
  // command decode and channel latches
  logic [10:0] cmd_word;
  logic [1:0] cmd_sel;
  logic cmd_range;
  logic [7:0] cmd_code;
  logic link_en_ff;
  logic soft_upd_ff;
  logic load_take;
  logic copy_all;
  logic [3:0][7:0] hold_code_ff;
  logic [3:0] hold_rng_ff;
  logic [3:0][7:0] out_code_ff;
  logic [3:0] out_rng_ff;
  logic [3:0][7:0] nxt_hold_code;
  logic [3:0] nxt_hold_rng;
  logic [3:0][7:0] nxt_out_code;
  logic [3:0] nxt_out_rng;
  logic [10:0] last_cmd_ff;
  logic [10:0] nxt_last_cmd;
  logic [7:0] cmd_count_ff;
  logic [7:0] nxt_cmd_count;

  // the word is read here only after the strobe settles, while the serial clock is idle
  assign cmd_word = shift_ff;
  assign cmd_sel = {cmd_word[quad_dac_loader_pkg::SEL_HI_POS], cmd_word[quad_dac_loader_pkg::SEL_LO_POS]};
  assign cmd_range = cmd_word[quad_dac_loader_pkg::RANGE_POS];
  assign cmd_code = cmd_word[quad_dac_loader_pkg::CODE_MSB:0];
  assign load_take = load_fall & link_en_ff;
  assign copy_all = upd_fall | soft_upd_ff;

  // holding latch always takes the word; output follows at once or on a joint update
  always_comb begin
    nxt_hold_code = hold_code_ff;
    nxt_hold_rng = hold_rng_ff;
    nxt_out_code = out_code_ff;
    nxt_out_rng = out_rng_ff;
    nxt_last_cmd = last_cmd_ff;
    nxt_cmd_count = cmd_count_ff;
    if (load_take) begin
      nxt_hold_code[cmd_sel] = cmd_code;
      nxt_hold_rng[cmd_sel] = cmd_range;
      nxt_last_cmd = cmd_word;
      nxt_cmd_count = cmd_count_ff + 8'h01;
    end
    if (copy_all) begin
      // new word in the same cycle is copied too, so it is not left behind
      nxt_out_code = nxt_hold_code;
      nxt_out_rng = nxt_hold_rng;
    end else if (load_take && !upd_level) begin
      nxt_out_code[cmd_sel] = cmd_code;
      nxt_out_rng[cmd_sel] = cmd_range;
    end
  end

  // power-on reset leaves every channel at code zero, unity span
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_code_ff <= {4{quad_dac_loader_pkg::CODE_RESET}};
      hold_rng_ff <= {4{quad_dac_loader_pkg::RANGE_RESET}};
      out_code_ff <= {4{quad_dac_loader_pkg::CODE_RESET}};
      out_rng_ff <= {4{quad_dac_loader_pkg::RANGE_RESET}};
      last_cmd_ff <= '0;
      cmd_count_ff <= 8'h00;
    end else begin
      hold_code_ff <= nxt_hold_code;
      hold_rng_ff <= nxt_hold_rng;
      out_code_ff <= nxt_out_code;
      out_rng_ff <= nxt_out_rng;
      last_cmd_ff <= nxt_last_cmd;
      cmd_count_ff <= nxt_cmd_count;
    end
  end

  assign output_channel_a = out_code_ff[0];
  assign output_channel_b = out_code_ff[1];
  assign output_channel_c = out_code_ff[2];
  assign output_channel_d = out_code_ff[3];
  assign range_double_a = out_rng_ff[0];
  assign range_double_b = out_rng_ff[1];
  assign range_double_c = out_rng_ff[2];
  assign range_double_d = out_rng_ff[3];

  // ==========================================================
  // register bus slave
  logic aw_got_ff, w_got_ff, bvalid_ff, awready_ff, wready_ff, arready_ff, rvalid_ff;
  logic nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_awready, nxt_wready, nxt_arready, nxt_rvalid;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic nxt_link_en, nxt_soft_upd;
  logic do_write;
  logic [31:0] rd_data;
  logic rd_ok;

  // read decode; unmapped addresses answer with a slave error and zero data
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == quad_dac_loader_pkg::CTRL_OFFS) begin
      rd_data[quad_dac_loader_pkg::CTRL_LINK_EN_POS] = link_en_ff;
    end else if (s_axi_araddr == quad_dac_loader_pkg::STATUS_OFFS) begin
      rd_data[quad_dac_loader_pkg::STATUS_UPD_POS] = upd_level;
      rd_data[quad_dac_loader_pkg::STATUS_LOAD_POS] = load_sync_ff[1];
      rd_data[quad_dac_loader_pkg::STATUS_COUNT_LSB +: 8] = cmd_count_ff;
    end else if (s_axi_araddr == quad_dac_loader_pkg::LAST_CMD_OFFS) begin
      rd_data[10:0] = last_cmd_ff;
    end else if (s_axi_araddr[7:4] == quad_dac_loader_pkg::OUT_BASE_OFFS[7:4] && s_axi_araddr[1:0] == 2'h0) begin
      rd_data[7:0] = out_code_ff[s_axi_araddr[3:2]];
      rd_data[quad_dac_loader_pkg::CHAN_RANGE_POS] = out_rng_ff[s_axi_araddr[3:2]];
    end else if (s_axi_araddr[7:4] == quad_dac_loader_pkg::HOLD_BASE_OFFS[7:4] && s_axi_araddr[1:0] == 2'h0) begin
      rd_data[7:0] = hold_code_ff[s_axi_araddr[3:2]];
      rd_data[quad_dac_loader_pkg::CHAN_RANGE_POS] = hold_rng_ff[s_axi_araddr[3:2]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // address and data are taken in either order; response once both are held
  always_comb begin
    nxt_aw_got = aw_got_ff | (s_axi_awvalid & awready_ff);
    nxt_w_got = w_got_ff | (s_axi_wvalid & wready_ff);
    nxt_awaddr = (s_axi_awvalid & awready_ff) ? s_axi_awaddr : awaddr_ff;
    nxt_wdata = (s_axi_wvalid & wready_ff) ? s_axi_wdata : wdata_ff;
    nxt_wstrb = (s_axi_wvalid & wready_ff) ? s_axi_wstrb : wstrb_ff;
    nxt_bvalid = bvalid_ff & ~s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_link_en = link_en_ff;
    nxt_soft_upd = 1'b0;
    do_write = aw_got_ff & w_got_ff & ~bvalid_ff;
    if (do_write) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = quad_dac_loader_pkg::RESP_OKAY;
      if (awaddr_ff == quad_dac_loader_pkg::CTRL_OFFS) begin
        if (wstrb_ff[0]) begin
          nxt_link_en = wdata_ff[quad_dac_loader_pkg::CTRL_LINK_EN_POS];
          nxt_soft_upd = wdata_ff[quad_dac_loader_pkg::CTRL_SOFT_UPD_POS];
        end
      end else if (awaddr_ff != quad_dac_loader_pkg::STATUS_OFFS && awaddr_ff != quad_dac_loader_pkg::LAST_CMD_OFFS
                   && awaddr_ff[7:4] != quad_dac_loader_pkg::OUT_BASE_OFFS[7:4]
                   && awaddr_ff[7:4] != quad_dac_loader_pkg::HOLD_BASE_OFFS[7:4]) begin
        nxt_bresp = quad_dac_loader_pkg::RESP_SLVERR;
      end
    end
    nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
    nxt_wready = ~nxt_w_got & ~nxt_bvalid;
    nxt_rvalid = rvalid_ff & ~s_axi_rready;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_data;
      nxt_rresp = rd_ok ? quad_dac_loader_pkg::RESP_OKAY : quad_dac_loader_pkg::RESP_SLVERR;
    end
    nxt_arready = ~nxt_rvalid;
  end

  // bus state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      rdata_ff <= 32'h0000_0000;
      bresp_ff <= 2'h0;
      rresp_ff <= 2'h0;
      link_en_ff <= quad_dac_loader_pkg::CTRL_LINK_EN_RESET;
      soft_upd_ff <= 1'b0;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      bvalid_ff <= nxt_bvalid;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      rdata_ff <= nxt_rdata;
      bresp_ff <= nxt_bresp;
      rresp_ff <= nxt_rresp;
      link_en_ff <= nxt_link_en;
      soft_upd_ff <= nxt_soft_upd;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ==========================================================
  // assertions
  a_shift_msb_first: assert property (@(negedge serial_clock) disable iff (!link_rst_n)
    link_rst_n |=> shift_ff == {$past(shift_ff[9:0]), $past(serial_data)})
    else $error("shift register did not take serial data on the falling edge");

  a_imm_output: assert property (@(posedge aclk) disable iff (!aresetn)
    load_take && !upd_level && !copy_all |=> out_code_ff[$past(cmd_sel)] == $past(cmd_code)
      && out_rng_ff[$past(cmd_sel)] == $past(cmd_range))
    else $error("immediate load did not reach the channel output");

  a_held_outputs: assert property (@(posedge aclk) disable iff (!aresetn)
    upd_level && !soft_upd_ff |=> $stable(out_code_ff) && $stable(out_rng_ff))
    else $error("output changed while the update strobe was high");

  a_joint_update: assert property (@(posedge aclk) disable iff (!aresetn)
    upd_fall && !load_take |=> out_code_ff == hold_code_ff && out_rng_ff == hold_rng_ff)
    else $error("update edge did not copy all holding latches");

  a_hold_load: assert property (@(posedge aclk) disable iff (!aresetn)
    load_take |=> hold_code_ff[$past(cmd_sel)] == $past(cmd_code) && hold_rng_ff[$past(cmd_sel)] == $past(cmd_range))
    else $error("holding latch missed a command");

  a_select_chan_a: assert property (@(posedge aclk) disable iff (!aresetn)
    load_take && cmd_word[10:9] == 2'h0 |=> $stable(hold_code_ff[1]) && $stable(hold_code_ff[2])
      && $stable(hold_code_ff[3]) && hold_code_ff[0] == $past(cmd_code))
    else $error("select 00 did not address channel a alone");

  a_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> out_code_ff == '0 && hold_code_ff == '0 && out_rng_ff == 4'h0)
    else $error("channel latches not cleared by reset");

  a_single_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    load_fall |=> !load_fall ##1 !load_fall)
    else $error("latch strobe edge acted more than once");

  a_hold_on_load: assert property (@(posedge aclk) disable iff (!aresetn)
    !load_take |=> $stable(hold_code_ff) && $stable(hold_rng_ff))
    else $error("holding latch changed without a latch strobe edge");

  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");

  c_imm_load: cover property (@(posedge aclk) disable iff (!aresetn) load_take && !upd_level);
  c_held_load: cover property (@(posedge aclk) disable iff (!aresetn) load_take && upd_level);
  c_joint_update: cover property (@(posedge aclk) disable iff (!aresetn) upd_fall);
  c_soft_update: cover property (@(posedge aclk) disable iff (!aresetn) soft_upd_ff);
endmodule : quad_dac_serial_loader

// ### host_serial_model.sv
/*
  host side of the three-wire serial link plus the update strobe.
  assumes the loader samples data on falling serial clock edges.
*/
`timescale 1ns/1ps
module host_serial_model (
  output logic serial_clock,
  output logic serial_data,
  output logic latch_strobe_n,
  output logic output_update_strobe
);
  // ====================
  // idle levels: clock parked high so each frame opens with a fall
  initial begin
    serial_clock = 1'b1;
    serial_data = 1'b0;
    latch_strobe_n = 1'b1;
    output_update_strobe = 1'b0;
  end

  // ====================
  // frame of n bits, msb first; data settles half a period before the fall
  task send_bits(input logic [15:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = w[i];
      #16 serial_clock = 1'b0;
      #16 serial_clock = 1'b1;
    end
    // released line has no pull, so show the inverse rather than a stale bit
    serial_data = ~serial_data;
  endtask : send_bits

  // one whole command word
  task send_word(input logic [10:0] w);
    send_bits({5'h00, w}, 11);
  endtask : send_word

  // strobe low only after the last bit; long phases cover the sync delay
  task pulse_load;
    #40 latch_strobe_n = 1'b0;
    #200 latch_strobe_n = 1'b1;
    #200;
  endtask : pulse_load

  // update strobe level, held long enough for the loader to see it
  task set_update(input logic v);
    output_update_strobe = v;
    #200;
  endtask : set_update
endmodule : host_serial_model

// ### tb_top.sv
/*
  self-checking bench for the quad converter serial loader: table of loads,
  then held update, soft update, long frame, bus errors and a second reset.
  assumes host_serial_model is compiled before this file.
*/
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [10:0] word;
    logic [1:0] ch;
    logic [8:0] res;
  } row_t;
  localparam row_t ROWS [0:5] = '{'{11'h0A5, 2'h0, 9'h0A5}, '{11'h33C, 2'h1, 9'h13C},
    '{11'h4FF, 2'h2, 9'h0FF}, '{11'h701, 2'h3, 9'h101}, '{11'h180, 2'h0, 9'h180}, '{11'h600, 2'h3, 9'h000}};
  localparam logic [10:0] HELD [0:3] = '{11'h04F, 11'h311, 11'h522, 11'h67E};
  logic aclk, aresetn, serial_clock, serial_data, latch_strobe_n, output_update_strobe;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] output_channel_a, output_channel_b, output_channel_c, output_channel_d;
  logic range_double_a, range_double_b, range_double_c, range_double_d;
  logic [8:0] exp_out [4];
  int err_count;
  int total_checks;

  quad_dac_serial_loader u_dut (
    .aclk, .aresetn, .serial_clock, .serial_data, .latch_strobe_n, .output_update_strobe,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .output_channel_a, .output_channel_b, .output_channel_c, .output_channel_d,
    .range_double_a, .range_double_b, .range_double_c, .range_double_d
  );
  host_serial_model u_host (.serial_clock, .serial_data, .latch_strobe_n, .output_update_strobe);

  // ====================
  // bus clock, 40 ns
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ====================
  // comparison and verdict
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  function automatic logic [8:0] chan_out(input int i);
    case (i)
      0: return {range_double_a, output_channel_a};
      1: return {range_double_b, output_channel_b};
      2: return {range_double_c, output_channel_c};
      default: return {range_double_d, output_channel_d};
    endcase
  endfunction : chan_out

  // every channel at once, so a wrong select shows as a change elsewhere
  task check_all;
    for (int i = 0; i < 4; i++) check({23'h0, chan_out(i)}, {23'h0, exp_out[i]});
  endtask : check_all

  // ====================
  // bus master; every change lands just after a rising edge
  task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    // the link reset only moves on falling serial edges, so clock a few while reset is low
    u_host.send_bits(16'h0000, 3);
    @(posedge aclk);
    aresetn <= 1'b1;
    // two more falls release the link reset before any frame starts
    u_host.send_bits(16'h0000, 2);
    @(posedge aclk);
  endtask : do_reset

  task load(input logic [10:0] w);
    u_host.send_word(w);
    u_host.pulse_load();
  endtask : load

  // ====================
  // hang guard, far beyond the fifteen or so microseconds the tests need
  initial begin
    #300000;
    err_count++;
    complete_run();
  end

  // ====================
  // main sequence
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    err_count = 0;
    total_checks = 0;
    exp_out = '{default: 9'h000};
    do_reset();
    check_all();
    axi_read(quad_dac_loader_pkg::CTRL_OFFS, rd, rs);
    check(rd, 32'h1);
    check({30'h0, rs}, {30'h0, quad_dac_loader_pkg::RESP_OKAY});
    // immediate loads, update strobe low
    foreach (ROWS[i]) begin
      load(ROWS[i].word);
      exp_out[ROWS[i].ch] = ROWS[i].res;
      check_all();
    end
    // held loads reach only the holding latches until the strobe falls
    u_host.set_update(1'b1);
    foreach (HELD[i]) load(HELD[i]);
    check_all();
    foreach (HELD[i]) begin
      axi_read(quad_dac_loader_pkg::HOLD_BASE_OFFS + 8'(4 * i), rd, rs);
      check(rd, {23'h0, HELD[i][8:0]});
    end
    axi_read(quad_dac_loader_pkg::LAST_CMD_OFFS, rd, rs);
    check(rd, {21'h0, HELD[3]});
    // ten accepted loads so far, both strobes synced high
    axi_read(quad_dac_loader_pkg::STATUS_OFFS, rd, rs);
    check(rd, 32'h0000_0A03);
    u_host.set_update(1'b0);
    foreach (HELD[i]) exp_out[i] = HELD[i][8:0];
    check_all();
    // software override copies while the strobe stays high
    u_host.set_update(1'b1);
    load(11'h2AA);
    check_all();
    axi_write(quad_dac_loader_pkg::CTRL_OFFS, 32'h3, rs);
    check({30'h0, rs}, {30'h0, quad_dac_loader_pkg::RESP_OKAY});
    repeat (4) @(posedge aclk);
    exp_out[1] = 9'h0AA;
    check_all();
    u_host.set_update(1'b0);
    // overlong frame: only the last eleven bits count
    u_host.send_bits(16'h1D5A, 13);
    u_host.pulse_load();
    exp_out[2] = 9'h15A;
    check_all();
    // unmapped place answers with an error and no data
    axi_read(8'hFC, rd, rs);
    check({30'h0, rs}, {30'h0, quad_dac_loader_pkg::RESP_SLVERR});
    check(rd, 32'h0);
    axi_write(8'hFC, 32'hFFFF_FFFF, rs);
    check({30'h0, rs}, {30'h0, quad_dac_loader_pkg::RESP_SLVERR});
    // link disabled: a latch strobe is ignored entirely
    axi_write(quad_dac_loader_pkg::CTRL_OFFS, 32'h0, rs);
    check({30'h0, rs}, {30'h0, quad_dac_loader_pkg::RESP_OKAY});
    load(11'h0FF);
    check_all();
    // second reset in mid-run clears every channel
    do_reset();
    exp_out = '{default: 9'h000};
    check_all();
    // link works again after the reset, link enable back at its reset value
    load(11'h33C);
    exp_out[1] = 9'h13C;
    check_all();
    complete_run();
  end
endmodule : tb_top
